// ==== operand_addressing_decoder.sv ====
// operand addressing decoder: operand fields to effective references
`timescale 1ns/100ps
`default_nettype none
module operand_addressing_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // request
  input wire logic req_valid,
  input wire operand_decoder_pkg::op_req_t req,
  input wire operand_decoder_pkg::slow_cause_t slow,
  // result
  output operand_decoder_pkg::op_res_t res_ff,
  output logic [2:0] extra_cycles_ff
);

  // dword index legality
  function automatic logic dword_ok(input logic [5:0] k);
    dword_ok = (k[1:0] == 2'b00) &&
      ((k <= operand_decoder_pkg::DWORD_LO_MAX) ||
       (k == operand_decoder_pkg::DWORD_HI_A) || (k == operand_decoder_pkg::DWORD_HI_B));
  endfunction : dword_ok

  // place a byte address in the low page
  function automatic logic [23:0] low_page_addr(input logic [7:0] a);
    low_page_addr = {16'h0000, a};
  endfunction : low_page_addr

  // place a word address in the first region
  function automatic logic [23:0] first_region_addr(input logic [15:0] a);
    first_region_addr = {8'h00, a};
  endfunction : first_region_addr

  // word register index j to register file number 2j
  function automatic logic [5:0] word_reg_num(input logic [3:0] j);
    word_reg_num = {1'b0, j, 1'b0};
  endfunction : word_reg_num

  operand_decoder_pkg::op_res_t nxt_res;
  logic [2:0] nxt_extra;
  logic [23:0] rel_sum;

  assign rel_sum = req.next_pc + {{16{req.field[7]}}, req.field[7:0]};

  // combinational decode of one operand
  always_comb begin
    nxt_res = '0;
    nxt_res.valid = req_valid;
    case (req.kind)
      operand_decoder_pkg::OP_REL: nxt_res.addr = rel_sum;
      operand_decoder_pkg::OP_BLOCK: nxt_res.addr = {req.next_pc[23:11], req.field[10:0]};
      operand_decoder_pkg::OP_REGION: nxt_res.addr = {req.next_pc[23:16], req.field[15:0]};
      operand_decoder_pkg::OP_FULL: nxt_res.addr = req.field;
      operand_decoder_pkg::OP_SHORT: begin
        case (req.field[1:0])
          2'b00: nxt_res.imm = 32'h00000001;
          2'b01: nxt_res.imm = 32'h00000002;
          2'b10: nxt_res.imm = 32'h00000004;
          default: nxt_res.bad_idx = 1'b1;
        endcase
      end
      operand_decoder_pkg::OP_ZEXT: nxt_res.imm = {16'h0000, req.field[15:0]};
      operand_decoder_pkg::OP_OEXT: nxt_res.imm = {16'hffff, req.field[15:0]};
      operand_decoder_pkg::OP_LBIT: begin
        nxt_res.is_bit = 1'b1;
        nxt_res.bit_pos = req.field[2:0];
        if (!req.field[7]) begin
          nxt_res.addr = low_page_addr(operand_decoder_pkg::LOW_BIT_BASE + {4'h0, req.field[6:3]});
        end else begin
          nxt_res.is_sfr = 1'b1;
          nxt_res.addr = low_page_addr({req.field[7:3], 3'b000});
        end
      end
      operand_decoder_pkg::OP_XBIT: begin
        nxt_res.is_bit = 1'b1;
        nxt_res.bit_pos = req.field[2:0];
        nxt_res.is_sfr = req.byte_direct_address_sfr;
        nxt_res.addr = low_page_addr(req.field[10:3]);
        if (!req.byte_direct_address_sfr && ((nxt_res.addr < operand_decoder_pkg::BIT_RAM_LO) ||
            (nxt_res.addr > operand_decoder_pkg::BIT_RAM_HI))) begin
          nxt_res.bad_idx = 1'b1;
        end
      end
      operand_decoder_pkg::OP_BYTE_DIRECT_ADDRESS: begin
        nxt_res.is_sfr = req.byte_direct_address_sfr;
        nxt_res.addr = low_page_addr(req.field[7:0]);
      end
      operand_decoder_pkg::OP_WORD_DIRECT_ADDRESS: nxt_res.addr = first_region_addr(req.field[15:0]);
      operand_decoder_pkg::OP_BREG: begin
        nxt_res.dst_reg = {2'b00, req.dst_idx};
        nxt_res.src_reg = {2'b00, req.src_idx};
      end
      operand_decoder_pkg::OP_BANK: nxt_res.dst_reg = {1'b0, req.bank, req.field[2:0]};
      operand_decoder_pkg::OP_LIND: begin
        nxt_res.src_reg = {1'b0, req.bank, 2'b00, req.field[0]};
        nxt_res.addr = low_page_addr(req.reg_val[7:0]);
      end
      operand_decoder_pkg::OP_WREG: begin
        nxt_res.dst_reg = word_reg_num(req.dst_idx);
        nxt_res.src_reg = word_reg_num(req.src_idx);
      end
      operand_decoder_pkg::OP_WIND: begin
        nxt_res.src_reg = word_reg_num(req.src_idx);
        nxt_res.addr = first_region_addr(req.reg_val[15:0]);
      end
      operand_decoder_pkg::OP_WDIS: begin
        nxt_res.src_reg = word_reg_num(req.src_idx);
        nxt_res.addr = first_region_addr(req.reg_val[15:0] + req.disp);
      end
      operand_decoder_pkg::OP_DREG, operand_decoder_pkg::OP_DIND,
      operand_decoder_pkg::OP_DDIS: begin
        if (dword_ok(req.dword_idx)) begin
          nxt_res.src_reg = req.dword_idx;
          if (req.kind == operand_decoder_pkg::OP_DIND) begin
            nxt_res.addr = req.reg_val[23:0];
          end else if (req.kind == operand_decoder_pkg::OP_DDIS) begin
            nxt_res.addr = req.reg_val[23:0] + {8'h00, req.disp};
          end
        end else begin
          nxt_res.bad_idx = 1'b1;
        end
      end
      default: nxt_res.valid = 1'b0;
    endcase
    if (!req_valid) begin
      nxt_res = '0;
    end
  end

  // extra execution cycles from slow accesses
  always_comb begin
    nxt_extra = 3'h0;
    if (req_valid) begin
      nxt_extra = (slow.ext_fetch ? operand_decoder_pkg::EXTRA_FETCH : 3'h0) +
        (slow.sfr_access ? operand_decoder_pkg::EXTRA_SFR : 3'h0) +
        (slow.ext_data ? operand_decoder_pkg::EXTRA_XDATA : 3'h0) +
        (slow.wait_state ? operand_decoder_pkg::EXTRA_WAIT : 3'h0) +
        (slow.long_ale ? operand_decoder_pkg::EXTRA_ALE : 3'h0);
    end
  end

  // result register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_ff <= '0;
    end else begin
      res_ff <= nxt_res;
    end
  end

  // penalty register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extra_cycles_ff <= 3'h0;
    end else begin
      extra_cycles_ff <= nxt_extra;
    end
  end

  // relative target is the next address plus the signed byte
  a_rel_target: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_REL
    |=> res_ff.addr == $past(req.next_pc) + 24'($signed($past(req.field[7:0]))))
    else $error("relative target wrong");

  // block target keeps the upper bits of the next address
  a_block_keep: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_BLOCK
    |=> res_ff.addr[23:11] == $past(req.next_pc[23:11]))
    else $error("block target left block");

  // block target takes its low bits from the operand
  a_block_low: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_BLOCK
    |=> res_ff.addr[10:0] == $past(req.field[10:0]))
    else $error("block target low bits wrong");

  // region target keeps the region of the next address
  a_region_keep: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_REGION
    |=> res_ff.addr == {$past(req.next_pc[23:16]), $past(req.field[15:0])})
    else $error("region target wrong");

  // full target is passed through whole
  a_full_target: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_FULL
    |=> res_ff.addr == $past(req.field))
    else $error("full target wrong");

  // short immediate stays within its three values
  a_short_vals: assert property (@(posedge clk) disable iff (!rstn)
    $past(req_valid) && $past(req.kind) == operand_decoder_pkg::OP_SHORT && !res_ff.bad_idx
    |-> res_ff.imm == 32'h1 || res_ff.imm == 32'h2 || res_ff.imm == 32'h4)
    else $error("short immediate out of set");

  // unused short code is flagged and yields no constant
  a_short_bad: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_SHORT && req.field[1:0] == 2'b11
    |=> res_ff.bad_idx && res_ff.imm == 32'h0)
    else $error("short code three accepted");

  // zero extended constant
  a_zext_high: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_ZEXT
    |=> res_ff.imm == {16'h0000, $past(req.field[15:0])})
    else $error("zero extension wrong");

  // one extended constant
  a_oext_high: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_OEXT
    |=> res_ff.imm == {16'hffff, $past(req.field[15:0])})
    else $error("one extension wrong");

  // lower legacy bits land in the bit ram bytes
  a_lbit_ram: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_LBIT && !req.field[7]
    |=> !res_ff.is_sfr && res_ff.addr >= 24'h20 && res_ff.addr <= 24'h2f)
    else $error("legacy bit ram map wrong");

  // upper legacy bits land in sfrs ending in 0 or 8
  a_lbit_sfr: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_LBIT && req.field[7]
    |=> res_ff.is_sfr && res_ff.addr[2:0] == 3'b000 && res_ff.addr[7])
    else $error("legacy bit sfr map wrong");

  // extended bit pairs byte address and bit position
  a_xbit_pos: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_XBIT
    |=> res_ff.is_bit && res_ff.bit_pos == $past(req.field[2:0]) && res_ff.addr[7:0] == $past(req.field[10:3]))
    else $error("extended bit fields wrong");

  // extended ram bit below the bit window is refused
  a_xbit_range: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_XBIT && !req.byte_direct_address_sfr && req.field[10:3] < 8'h20
    |=> res_ff.bad_idx)
    else $error("extended bit below ram window");

  // byte direct address stays in the low page of its space
  a_byte_direct_address_space: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_BYTE_DIRECT_ADDRESS
    |=> res_ff.is_sfr == $past(req.byte_direct_address_sfr) && res_ff.addr[23:8] == 16'h0000)
    else $error("byte direct space wrong");

  // word direct address stays in the first region
  a_word_direct_address_low: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_WORD_DIRECT_ADDRESS
    |=> res_ff.addr == {8'h00, $past(req.field[15:0])})
    else $error("word direct left region");

  // byte register fields name registers 0 to 15
  a_breg_index: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_BREG
    |=> res_ff.dst_reg == {2'b00, $past(req.dst_idx)} && res_ff.src_reg == {2'b00, $past(req.src_idx)})
    else $error("byte register index wrong");

  // legacy register is one of eight in the selected bank
  a_bank_index: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_BANK
    |=> res_ff.dst_reg[5:3] == {1'b0, $past(req.bank)} && res_ff.dst_reg[2:0] == $past(req.field[2:0]))
    else $error("bank register wrong");

  // legacy indirect uses register 0 or 1 and a low page address
  a_lind_low: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_LIND
    |=> res_ff.addr == {16'h0000, $past(req.reg_val[7:0])} && res_ff.src_reg[2:1] == 2'b00)
    else $error("legacy indirect wrong");

  // word registers are even
  a_wreg_even: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_WREG
    |=> !res_ff.dst_reg[0] && !res_ff.src_reg[0])
    else $error("odd word register");

  // word indirect address is the register content in the first region
  a_wind_region: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_WIND
    |=> res_ff.addr == {8'h00, $past(req.reg_val[15:0])})
    else $error("word indirect wrong");

  // word displacement never leaves the first region
  a_wdis_region: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_WDIS
    |=> res_ff.addr[23:16] == 8'h00)
    else $error("word displacement left region");

  // accepted dword registers are in the legal set
  a_dword_legal: assert property (@(posedge clk) disable iff (!rstn)
    $past(req_valid) && $past(req.kind) == operand_decoder_pkg::OP_DREG && !res_ff.bad_idx
    |-> res_ff.src_reg[1:0] == 2'b00 && (res_ff.src_reg <= 6'h1c || res_ff.src_reg[5:3] == 3'b111))
    else $error("illegal dword register accepted");

  // dword indirect uses the low 24 bits of the register content
  a_dind_full: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_DIND && req.dword_idx <= 6'h1c && req.dword_idx[1:0] == 2'b00
    |=> res_ff.addr == $past(req.reg_val[23:0]) && !res_ff.bad_idx)
    else $error("dword indirect wrong");

  // dword displacement adds over the full space
  a_ddis_sum: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_DDIS && req.dword_idx <= 6'h1c && req.dword_idx[1:0] == 2'b00
    |=> res_ff.addr == $past(req.reg_val[23:0]) + {8'h00, $past(req.disp)})
    else $error("dword displacement wrong");

  // dword indices in the gap are refused
  a_dword_bad: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind == operand_decoder_pkg::OP_DREG && req.dword_idx >= 6'h20 && req.dword_idx <= 6'h34
    |=> res_ff.bad_idx && res_ff.src_reg == 6'h00)
    else $error("invalid dword decoded");

  // a wait state lengthens execution
  a_slow_extra: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && slow.wait_state
    |=> extra_cycles_ff != 3'h0)
    else $error("wait state added no time");

  // no slow cause adds no time
  a_extra_none: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && slow == '0
    |=> extra_cycles_ff == 3'h0)
    else $error("time added without cause");

  // every slow cause adds its own cycle
  a_extra_all: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && slow == 5'h1f
    |=> extra_cycles_ff == 3'h5)
    else $error("all causes total wrong");

  // no request leaves the outputs at zero
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !req_valid
    |=> res_ff == '0 && extra_cycles_ff == 3'h0)
    else $error("output without request");

  // an unknown operand kind gives no valid result
  a_kind_unknown: assert property (@(posedge clk) disable iff (!rstn)
    req_valid && req.kind > operand_decoder_pkg::OP_DDIS
    |=> !res_ff.valid)
    else $error("unknown kind decoded");

endmodule : operand_addressing_decoder
`default_nettype wire

// ==== operand_decoder_pkg.sv ====
// package for the operand addressing decoder
package operand_decoder_pkg;
  localparam int ADDR_W = 24;
  localparam logic [7:0] LOW_BIT_BASE = 8'h20;
  localparam logic [7:0] SFR_BIT_BASE = 8'h80;
  localparam logic [23:0] BIT_RAM_LO = 24'h000020;
  localparam logic [23:0] BIT_RAM_HI = 24'h00007f;
  localparam logic [5:0] DWORD_HI_A = 6'h38;
  localparam logic [5:0] DWORD_HI_B = 6'h3c;
  localparam logic [5:0] DWORD_LO_MAX = 6'h1c;
  localparam logic [2:0] EXTRA_FETCH = 3'h1;
  localparam logic [2:0] EXTRA_SFR = 3'h1;
  localparam logic [2:0] EXTRA_XDATA = 3'h1;
  localparam logic [2:0] EXTRA_WAIT = 3'h1;
  localparam logic [2:0] EXTRA_ALE = 3'h1;

  // operand kinds presented to the decoder
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_REL = 5'h01,
    OP_BLOCK = 5'h02,
    OP_REGION = 5'h03,
    OP_FULL = 5'h04,
    OP_SHORT = 5'h05,
    OP_ZEXT = 5'h06,
    OP_OEXT = 5'h07,
    OP_LBIT = 5'h08,
    OP_XBIT = 5'h09,
    OP_BYTE_DIRECT_ADDRESS = 5'h0a,
    OP_WORD_DIRECT_ADDRESS = 5'h0b,
    OP_BREG = 5'h0c,
    OP_BANK = 5'h0d,
    OP_LIND = 5'h0e,
    OP_WREG = 5'h0f,
    OP_WIND = 5'h10,
    OP_WDIS = 5'h11,
    OP_DREG = 5'h12,
    OP_DIND = 5'h13,
    OP_DDIS = 5'h14
  } op_kind_t;

  // request into the decoder
  typedef struct packed {
    op_kind_t kind;
    logic [23:0] next_pc;
    logic [23:0] field;
    logic [3:0] dst_idx;
    logic [3:0] src_idx;
    logic [5:0] dword_idx;
    logic [1:0] bank;
    logic byte_direct_address_sfr;
    logic [31:0] reg_val;
    logic [15:0] disp;
  } op_req_t;

  // decoded result
  typedef struct packed {
    logic valid;
    logic bad_idx;
    logic is_sfr;
    logic is_bit;
    logic [2:0] bit_pos;
    logic [23:0] addr;
    logic [31:0] imm;
    logic [5:0] dst_reg;
    logic [5:0] src_reg;
  } op_res_t;

  // timing penalty causes
  typedef struct packed {
    logic ext_fetch;
    logic sfr_access;
    logic ext_data;
    logic wait_state;
    logic long_ale;
  } slow_cause_t;
endpackage : operand_decoder_pkg

// ==== test_operand_addressing_decoder.sv ====
// self-checking testbench for the operand addressing decoder
`timescale 1ns/100ps
`default_nettype none
module test_operand_addressing_decoder;
  // stimulus, observed outputs and counters
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  operand_decoder_pkg::op_req_t req = '0;
  operand_decoder_pkg::slow_cause_t slow = '0;
  operand_decoder_pkg::op_res_t res_ff;
  logic [2:0] extra_cycles_ff;
  int num_errors = 0;
  int samples_checked = 0;
  logic [5:0] ks [7] = '{6'h00, 6'h1c, 6'h38, 6'h3c, 6'h20, 6'h34, 6'h02};
  // 25 ns clock
  always #12.5 clk = ~clk;
  operand_addressing_decoder DUT (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req), .slow(slow),
    .res_ff(res_ff), .extra_cycles_ff(extra_cycles_ff));
  // compare one observed value
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", what, e, g);
      num_errors++;
    end
  endtask : chk
  // drive one request at the falling edge, return just after the answering edge
  task go(input logic [4:0] k, input logic [23:0] f, input logic [23:0] pc = 24'h0, input logic [31:0] rv = 32'h0,
    input logic [15:0] ds = 16'h0, input logic [7:0] ix = 8'h0, input logic [4:0] sl = 5'h0, input logic v = 1'b1);
    @(negedge clk);
    req_valid = v;
    req = '{kind: operand_decoder_pkg::op_kind_t'(k), next_pc: pc, field: f, dst_idx: ix[7:4], src_idx: ix[3:0],
      dword_idx: ix[5:0], bank: ix[7:6], byte_direct_address_sfr: ix[0], reg_val: rv, disp: ds};
    slow = operand_decoder_pkg::slow_cause_t'(sl);
    @(posedge clk);
    #1;
  endtask : go
  // branch targets and immediates
  task t_jumps;
    go(5'h01, 24'hfe, 24'h100);
    chk("rel back", 32'h010000fe, {res_ff.valid, res_ff.addr});
    go(5'h01, 24'h80, 24'h100);
    chk("rel min", 32'h80, res_ff.addr);
    go(5'h02, 24'h7ff, 24'h123456);
    chk("block", 32'h1237ff, res_ff.addr);
    go(5'h03, 24'hbeef, 24'h7a1234);
    chk("region", 32'h7abeef, res_ff.addr);
    go(5'h04, 24'hfedcba, 24'h7a1234);
    chk("full", 32'hfedcba, res_ff.addr);
    for (int i = 0; i < 3; i++) begin
      go(5'h05, 24'(i));
      chk("short", 32'h1 << i, res_ff.imm);
    end
    go(5'h05, 24'h3);
    chk("short bad", 32'h1, res_ff.bad_idx);
    go(5'h06, 24'h8001);
    chk("zext", 32'h00008001, res_ff.imm);
    go(5'h07, 24'h8001);
    chk("oext", 32'hffff8001, res_ff.imm);
    $display("test jumps done");
  endtask : t_jumps
  // bit and direct addresses
  task t_bits;
    go(5'h08, 24'h0b);
    chk("ram bit", 32'h1000010b, {res_ff.is_bit, res_ff.is_sfr, res_ff.addr, res_ff.bit_pos});
    go(5'h08, 24'hfb);
    chk("sfr bit", 32'h010000f8, {res_ff.is_sfr, res_ff.addr});
    go(5'h09, 24'h3fd);
    chk("xbit", 32'h3fd, {res_ff.bad_idx, res_ff.addr, res_ff.bit_pos});
    go(5'h09, 24'h0f8);
    chk("xbit low", 32'h1, res_ff.bad_idx);
    go(5'h0a, 24'h45, , , , 8'h01);
    chk("byte_direct_address sfr", 32'h145, {res_ff.is_sfr, res_ff.addr[7:0]});
    go(5'h0a, 24'h45);
    chk("byte_direct_address ram", 32'h45, {res_ff.is_sfr, res_ff.addr});
    go(5'h0b, 24'hbeef);
    chk("word_direct_address", 32'hbeef, res_ff.addr);
    $display("test bits done");
  endtask : t_bits
  // register operands and register based addresses
  task t_regs;
    go(5'h0c, 24'h0, , , , 8'hf3);
    chk("byte regs", 32'h0f03, {2'h0, res_ff.dst_reg, 2'h0, res_ff.src_reg});
    go(5'h0d, 24'h5, , , , 8'h80);
    chk("bank reg", 32'h15, {26'h0, res_ff.dst_reg});
    go(5'h0e, 24'h1, , 32'h123456a5, , 8'hc0);
    chk("low ind", 32'h190000a5, {2'h0, res_ff.src_reg, res_ff.addr});
    go(5'h0f, 24'h0, , , , 8'hf0);
    chk("word reg", 32'h1e00, {2'h0, res_ff.dst_reg, 2'h0, res_ff.src_reg});
    go(5'h10, 24'h0, , 32'h1234abcd);
    chk("word ind", 32'habcd, res_ff.addr);
    go(5'h11, 24'h0, , 32'h0000ffff, 16'h0002);
    chk("word disp", 32'h1, res_ff.addr);
    for (int i = 0; i < 7; i++) begin
      go(5'h12, 24'h0, , , , {2'h0, ks[i]});
      chk("dword reg", (i > 3) ? 32'h100 : {26'h0, ks[i]}, {res_ff.bad_idx, 2'h0, res_ff.src_reg});
    end
    go(5'h13, 24'h0, , 32'haafedcba);
    chk("dword ind", 32'hfedcba, res_ff.addr);
    go(5'h14, 24'h0, , 32'h00123400, 16'h8000);
    chk("dword disp", 32'h12b400, res_ff.addr);
    $display("test regs done");
  endtask : t_regs
  // penalties, idle cycle and a reset in mid-run
  task t_misc;
    for (int i = 0; i < 5; i++) begin
      go(5'h0a, 24'h0, , , , , 5'h1 << i);
      chk("one cause", 32'h1, extra_cycles_ff);
    end
    go(5'h0a, 24'h0, , , , , 5'h1f);
    chk("all causes", 32'h5, extra_cycles_ff);
    go(5'h01, 24'h0, , , , , 5'h0, 1'b0);
    chk("idle", 32'h0, {res_ff.valid, extra_cycles_ff});
    go(5'h15, 24'h123456);
    chk("bad kind", 32'h0, {31'h0, res_ff.valid});
    go(5'h04, 24'h123456);
    @(negedge clk);
    rstn = 1'b0;
    #1;
    chk("mid reset", 32'h0, {31'h0, res_ff != '0});
    @(negedge clk);
    rstn = 1'b1;
    $display("test misc done");
  endtask : t_misc
  // counts, verdict and end of run
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // reset, then the scenarios
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    #1;
    chk("after reset", 32'h0, {28'h0, res_ff != '0, extra_cycles_ff});
    t_jumps;
    t_bits;
    t_regs;
    t_misc;
    print_verdict;
  end
  // cut a hang short
  initial begin
    repeat (2000) @(posedge clk);
    $display("unexpected run time expected finished seen running");
    num_errors++;
    print_verdict;
  end
endmodule : test_operand_addressing_decoder
`default_nettype wire
